// ### design/jse_pkg.sv
package jse_pkg;

  // ------------------------------------------------------------
  // Register map (word offsets, byte address = 4 x index)
  // ------------------------------------------------------------
  localparam logic [7:0] JSE_TPE_IDX = 8'hC7;            // test_port_enable_ctrl
  localparam logic [7:0] JSE_STAT_IDX = 8'hC8;           // status readback
  localparam logic [7:0] JSE_PROT_IDX = 8'hC9;           // sector protect bits
  localparam logic [7:0] JSE_SEC_IDX = 8'hCA;            // security bit
  localparam int JSE_TPE_EN_BIT = 0;
  localparam logic [7:0] JSE_TPE_RST = 8'h00;
  localparam logic [31:0] JSE_ZERO32 = 32'h0000_0000;

  // ------------------------------------------------------------
  // Serial command codes (8-bit instruction register)
  // ------------------------------------------------------------
  localparam int JSE_IR_W = 8;
  localparam logic [7:0] JSE_CMD_ENTER = 8'h10;          // config_mode_enter_cmd
  localparam logic [7:0] JSE_CMD_EXIT = 8'h11;           // config_mode_exit_cmd
  localparam logic [7:0] JSE_CMD_CLEAR = 8'h12;          // error_clear_cmd
  localparam logic [7:0] JSE_CMD_CHIP_ERASE = 8'h20;
  localparam logic [7:0] JSE_CMD_SECT_ERASE = 8'h21;
  localparam logic [7:0] JSE_CMD_PROGRAM = 8'h22;
  localparam logic [7:0] JSE_CMD_VERIFY = 8'h23;
  localparam logic [7:0] JSE_CMD_READ = 8'h24;
  localparam logic [7:0] JSE_CMD_IDLE = 8'h00;
  // Option bits carried in the low nibble of the enter data byte
  localparam int JSE_OPT_EXT_BIT = 0;                    // enable status/error pins
  localparam int JSE_OPT_OD_BIT = 1;                     // open-drain drive
  localparam logic [7:0] JSE_ALL_ONES = 8'hFF;           // secured content reads and read capture reset value

  // TAP states
  typedef enum logic [3:0] {
    JSE_RESET, JSE_IDLE, JSE_SEL_DR, JSE_CAP_DR, JSE_SH_DR, JSE_EX1_DR, JSE_PA_DR,
    JSE_EX2_DR, JSE_UPD_DR, JSE_SEL_IR, JSE_CAP_IR, JSE_SH_IR, JSE_EX1_IR, JSE_PA_IR,
    JSE_EX2_IR, JSE_UPD_IR
  } jse_tap_e;

endpackage

// ### design/jse_sync.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------
module jse_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;

  // First stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule // jse_sync

// ### design/jse_top.sv
`timescale 1ns/100ps
// Functional notes
// - Extensions turn on only after enter command
// - Flash error drives error pin low
// - Error holds until clear or reset-after-exit
// - Status high while both arrays readable
// - Status low during program, erase, secondary write
// - Enter option selects open-drain extension drive
// - Secured device refuses every content read
// - Secured: only full chip erase accepted
// - Chip erase completion clears security
// - Protected sectors reject erase
// - Blank state: memory ones, config zeros
// - Enable register bit 0 switches port
// - Dedicated pins ignore chip reset
// - Register-enabled port aborted by chip reset
// - Port on if dedicate, register, or term
// - Enable register at C7h, reset clears
// - Data out driven only after enter command
module jse_top #(
  parameter int SECTORS = 12
) (
  input wire logic clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device level inputs
  input wire logic chip_reset,
  input wire logic nvm_dedicate,
  input wire logic pin_enable_term,
  // Flash engine interface
  input wire logic flash_busy,
  input wire logic sec_write_busy,
  input wire logic flash_fail,
  input wire logic flash_done,
  output logic [jse_pkg::JSE_IR_W-1:0] flash_cmd,
  output logic [7:0] flash_arg,
  output logic flash_start,
  // Serial test pins
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo_o,
  output logic tdo_oe,
  output logic port_active,
  // Extension pins, shared with general I/O
  input wire logic gpio_stat_o,
  input wire logic gpio_stat_oe,
  input wire logic gpio_err_o,
  input wire logic gpio_err_oe,
  output logic flash_status_out,
  output logic flash_status_oe,
  output logic flash_error_out,
  output logic flash_error_oe
);
  import jse_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisation and test clock edge detect
  // ------------------------------------------------------------
  logic [2:0] pins_s;
  logic tck_d_q;
  logic tck_rise;
  logic tck_fall;

  jse_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({tck_pin, tms_pin, tdi_pin}),
    .q(pins_s)
  );

  // Remember last synced test clock for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_d_q <= 1'b0;
    end else begin
      tck_d_q <= pins_s[2];
    end
  end
  assign tck_rise = pins_s[2] & ~tck_d_q;
  assign tck_fall = ~pins_s[2] & tck_d_q;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] tpe_q;
  logic [SECTORS-1:0] prot_q;
  logic secure_q;
  logic wb_req;
  logic [7:0] wb_idx;
  logic port_on;
  logic port_hold;
  logic cfg_q;
  logic ext_en_q;
  logic od_q;
  logic err_q;
  logic exit_seen_q;
  logic chip_rst_s;
  logic [7:0] read_q;
  logic wb_wr;

  // Request taken while no ack is out; writes land on the edge that samples ack
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wb_idx = wb_adr_i[9:2];

  // Ack one cycle after request, drops next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Enable register; a chip reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tpe_q <= JSE_TPE_RST;
    end else if (chip_rst_s) begin
      tpe_q <= JSE_TPE_RST;
    end else if (wb_wr && wb_sel_i[0] && wb_idx == JSE_TPE_IDX) begin
      tpe_q <= wb_dat_i[7:0]; // upper bits stored as written
    end
  end

  // Protect and security bits stand in for the nonvolatile configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_q <= '0;
    end else if (wb_wr && wb_idx == JSE_PROT_IDX) begin
      prot_q <= wb_dat_i[SECTORS-1:0];
    end
  end

  // Completed chip erase unsecures the part; erase wins over a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secure_q <= 1'b0;
    end else if (flash_done && flash_cmd == JSE_CMD_CHIP_ERASE) begin
      secure_q <= 1'b0;
    end else if (wb_wr && wb_sel_i[0] && wb_idx == JSE_SEC_IDX) begin
      secure_q <= wb_dat_i[0];
    end
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= JSE_ZERO32;
    end else if (wb_req && !wb_we_i) begin
      case (wb_idx)
        JSE_TPE_IDX: wb_dat_o <= {24'h000000, tpe_q};
        JSE_STAT_IDX: wb_dat_o <= {26'h0, port_on, secure_q, err_q, od_q, ext_en_q, cfg_q};
        JSE_PROT_IDX: wb_dat_o <= {{(32 - SECTORS){1'b0}}, prot_q};
        JSE_SEC_IDX: wb_dat_o <= {31'h0, secure_q};
        default: wb_dat_o <= JSE_ZERO32;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Port enable and reset interaction
  // ------------------------------------------------------------
  logic rst_pipe_q;

  // Chip reset pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_pipe_q <= 1'b0;
      chip_rst_s <= 1'b0;
    end else begin
      rst_pipe_q <= chip_reset;
      chip_rst_s <= rst_pipe_q;
    end
  end

  assign port_on = nvm_dedicate | tpe_q[JSE_TPE_EN_BIT] | pin_enable_term;
  // Any enable without the dedicate pin (register or term) is abortable by chip reset
  assign port_hold = ~port_on | (chip_rst_s & ~nvm_dedicate);
  assign port_active = port_on;

  // ------------------------------------------------------------
  // TAP controller, stepped on synced test clock rises
  // ------------------------------------------------------------
  jse_tap_e tap_q;
  jse_tap_e tap_d;
  logic [JSE_IR_W-1:0] ir_sh_q;
  logic [JSE_IR_W-1:0] ir_q;
  logic [7:0] dr_sh_q;

  always_comb begin
    tap_d = tap_q;
    case (tap_q)
      JSE_RESET: tap_d = pins_s[1] ? JSE_RESET : JSE_IDLE;
      JSE_IDLE: tap_d = pins_s[1] ? JSE_SEL_DR : JSE_IDLE;
      JSE_SEL_DR: tap_d = pins_s[1] ? JSE_SEL_IR : JSE_CAP_DR;
      JSE_CAP_DR: tap_d = pins_s[1] ? JSE_EX1_DR : JSE_SH_DR;
      JSE_SH_DR: tap_d = pins_s[1] ? JSE_EX1_DR : JSE_SH_DR;
      JSE_EX1_DR: tap_d = pins_s[1] ? JSE_UPD_DR : JSE_PA_DR;
      JSE_PA_DR: tap_d = pins_s[1] ? JSE_EX2_DR : JSE_PA_DR;
      JSE_EX2_DR: tap_d = pins_s[1] ? JSE_UPD_DR : JSE_SH_DR;
      JSE_UPD_DR: tap_d = pins_s[1] ? JSE_SEL_DR : JSE_IDLE;
      JSE_SEL_IR: tap_d = pins_s[1] ? JSE_RESET : JSE_CAP_IR;
      JSE_CAP_IR: tap_d = pins_s[1] ? JSE_EX1_IR : JSE_SH_IR;
      JSE_SH_IR: tap_d = pins_s[1] ? JSE_EX1_IR : JSE_SH_IR;
      JSE_EX1_IR: tap_d = pins_s[1] ? JSE_UPD_IR : JSE_PA_IR;
      JSE_PA_IR: tap_d = pins_s[1] ? JSE_EX2_IR : JSE_PA_IR;
      JSE_EX2_IR: tap_d = pins_s[1] ? JSE_UPD_IR : JSE_SH_IR;
      JSE_UPD_IR: tap_d = pins_s[1] ? JSE_SEL_DR : JSE_IDLE;
      default: tap_d = JSE_RESET;
    endcase
  end

  // Held in reset state while the port is off or aborted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_q <= JSE_RESET;
    end else if (port_hold) begin
      tap_q <= JSE_RESET;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // Instruction and data shift registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_sh_q <= JSE_CMD_IDLE;
      ir_q <= JSE_CMD_IDLE;
      dr_sh_q <= 8'h00;
    end else if (port_hold) begin
      ir_q <= JSE_CMD_IDLE;
    end else if (tck_rise) begin
      case (tap_q)
        JSE_CAP_IR: ir_sh_q <= JSE_CMD_IDLE;
        JSE_SH_IR: ir_sh_q <= {pins_s[0], ir_sh_q[JSE_IR_W-1:1]};
        JSE_UPD_IR: ir_q <= ir_sh_q;
        JSE_CAP_DR: dr_sh_q <= read_q;
        JSE_SH_DR: dr_sh_q <= {pins_s[0], dr_sh_q[7:1]};
        default: ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command execution at data update
  // ------------------------------------------------------------
  logic upd;
  logic allowed;
  assign upd = tck_rise & ~port_hold & (tap_q == JSE_UPD_DR);
  // Secured parts accept only chip erase protected sectors refuse erase
  assign allowed = (!secure_q || ir_q == JSE_CMD_CHIP_ERASE) &&
                   !(ir_q == JSE_CMD_SECT_ERASE && dr_sh_q < 8'(SECTORS) &&
                     prot_q[dr_sh_q[3:0]]);

  // Config mode and extension options
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 1'b0;
      ext_en_q <= 1'b0;
      od_q <= 1'b0;
    end else if (port_hold) begin
      cfg_q <= 1'b0;
      ext_en_q <= 1'b0;
      od_q <= 1'b0;
    end else if (upd && ir_q == JSE_CMD_ENTER) begin
      cfg_q <= 1'b1;
      ext_en_q <= dr_sh_q[JSE_OPT_EXT_BIT];
      od_q <= dr_sh_q[JSE_OPT_OD_BIT];
    end else if (upd && ir_q == JSE_CMD_EXIT) begin
      cfg_q <= 1'b0;
    end
  end

  // Flash command launch, one-cycle start pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_start <= 1'b0;
      flash_cmd <= JSE_CMD_IDLE;
      flash_arg <= 8'h00;
    end else begin
      flash_start <= 1'b0;
      if (upd && cfg_q && allowed && ir_q >= JSE_CMD_CHIP_ERASE &&
          ir_q <= JSE_CMD_VERIFY) begin
        flash_start <= 1'b1;
        flash_cmd <= ir_q;
        flash_arg <= dr_sh_q;
      end
    end
  end

  // Read capture; secured content reads as ones, otherwise the error flag in bit 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      read_q <= JSE_ALL_ONES;
    end else if (ir_q == JSE_CMD_READ) begin
      read_q <= secure_q ? JSE_ALL_ONES : {7'h00, err_q};
    end else begin
      read_q <= {6'h00, err_q, ~(flash_busy | sec_write_busy)};
    end
  end

  // ------------------------------------------------------------
  // Error latch; a new failure wins over a clear
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
      exit_seen_q <= 1'b0;
    end else begin
      if (upd && ir_q == JSE_CMD_EXIT) begin
        exit_seen_q <= 1'b1;
      end else if (upd && ir_q == JSE_CMD_ENTER) begin
        exit_seen_q <= 1'b0;
      end
      if (flash_fail) begin
        err_q <= 1'b1;
      end else if ((upd && ir_q == JSE_CMD_CLEAR) || (chip_rst_s && exit_seen_q)) begin
        err_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic stat_lvl;
  assign stat_lvl = ~(flash_busy | sec_write_busy);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      if (tck_fall) begin
        tdo_o <= (tap_q == JSE_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
      end
      tdo_oe <= cfg_q && !port_hold && (tap_q == JSE_SH_DR || tap_q == JSE_SH_IR);
    end
  end

  // Extensions or general I/O; open drain only drives low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_status_out <= 1'b0;
      flash_status_oe <= 1'b0;
      flash_error_out <= 1'b0;
      flash_error_oe <= 1'b0;
    end else if (ext_en_q) begin
      flash_status_out <= stat_lvl;
      flash_status_oe <= od_q ? ~stat_lvl : 1'b1;
      flash_error_out <= ~err_q;
      flash_error_oe <= od_q ? err_q : 1'b1;
    end else begin
      flash_status_out <= gpio_stat_o;
      flash_status_oe <= gpio_stat_oe;
      flash_error_out <= gpio_err_o;
      flash_error_oe <= gpio_err_oe;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_err_on_fail: assert property (@(posedge clk) disable iff (rst)
    flash_fail ##1 ext_en_q |=> (flash_error_out == 1'b0))
    else $error("error pin not low after failure");
  a_err_holds: assert property (@(posedge clk) disable iff (rst)
    (err_q && !(upd && ir_q == JSE_CMD_CLEAR) && !chip_rst_s) |=> err_q)
    else $error("error flag dropped without clear");
  a_stat_busy: assert property (@(posedge clk) disable iff (rst)
    (ext_en_q && flash_busy) ##1 ext_en_q |-> !flash_status_out)
    else $error("status high while busy");
  a_ext_gated: assert property (@(posedge clk) disable iff (rst)
    $rose(ext_en_q) |-> cfg_q)
    else $error("extensions on without enter");
  a_secure_only: assert property (@(posedge clk) disable iff (rst)
    (flash_start && secure_q) |-> flash_cmd == JSE_CMD_CHIP_ERASE)
    else $error("command accepted while secured");
  a_port_or: assert property (@(posedge clk) disable iff (rst)
    port_active == (nvm_dedicate | tpe_q[JSE_TPE_EN_BIT] | pin_enable_term))
    else $error("port enable not the OR of sources");
  a_tdo_quiet: assert property (@(posedge clk) disable iff (rst)
    !$past(cfg_q) |-> !tdo_oe)
    else $error("data out driven before enter");
  a_reg_reset: assert property (@(posedge clk) disable iff (rst)
    chip_rst_s |=> tpe_q == JSE_TPE_RST)
    else $error("enable register survived reset");
  a_tap_abort: assert property (@(posedge clk) disable iff (rst)
    (chip_rst_s && !nvm_dedicate) |=> tap_q == JSE_RESET)
    else $error("operation not aborted by reset");
endmodule // jse_top

// ### test/jse_jtag_ctl.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Behavioural serial programming controller
// ------------------------------------------------------------
module jse_jtag_ctl (
  input wire logic clk,
  input wire logic tdo,
  output logic tck_pin,
  output logic tms_pin,
  output logic tdi_pin,
  output logic [7:0] rx_byte
);
  logic tdo_smp;

  // Link clock parked low between frames
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b0;
    rx_byte = 8'h00;
    tdo_smp = 1'b0;
  end

  // One 800 ns link period: data moves on the fall, device samples on the rise
  task automatic tck_bit(input logic m, input logic d);
    @(posedge clk);
    tck_pin <= 1'b0;
    tms_pin <= m;
    tdi_pin <= d;
    repeat (4) @(posedge clk);
    tdo_smp = tdo; // Serial out settles three clocks after the fall
    tck_pin <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Idle -> shift -> update -> idle, 8 bits LSB first
  task automatic shift8(input logic ir, input logic [7:0] v);
    int i;
    tck_bit(1'b1, 1'b0);
    if (ir) tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
    tck_bit(1'b0, 1'b0);
    for (i = 0; i < 8; i++) begin
      tck_bit(i == 7, v[i]);
      if (!ir) rx_byte[i] = tdo_smp;
    end
    tck_bit(1'b1, 1'b0);
    tck_bit(1'b0, 1'b0);
  endtask

  // Full command: clean TAP reset, instruction, then its data byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
    int i;
    for (i = 0; i < 5; i++) begin
      tck_bit(1'b1, 1'b0);
    end
    tck_bit(1'b0, 1'b0);
    shift8(1'b1, op);
    shift8(1'b0, arg);
    @(posedge clk);
    tck_pin <= 1'b0;
    tdi_pin <= ~tdi_pin; // Released line must not keep its old level
    repeat (2) @(posedge clk); // Launch log settles before callers compare
  endtask
endmodule // jse_jtag_ctl

// ### test/jse_top_tb.sv
`timescale 1ns/100ps
module jse_top_tb;
  import jse_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] rx_byte;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic chip_reset = 1'b0, nvm_dedicate = 1'b0, pin_enable_term = 1'b0;
  logic flash_busy = 1'b0, sec_write_busy = 1'b0, flash_fail = 1'b0, flash_done = 1'b0;
  logic gpio_stat_o = 1'b1, gpio_stat_oe = 1'b0, gpio_err_o = 1'b0, gpio_err_oe = 1'b1;
  logic tck_pin, tms_pin, tdi_pin, wb_ack_o, tdo_o, tdo_oe, port_active, flash_start;
  logic flash_status_out, flash_status_oe, flash_error_out, flash_error_oe;
  logic saw_oe = 1'b0;
  logic [31:0] wb_dat_o, rdat;
  logic [7:0] flash_cmd, flash_arg, last_cmd = 8'h00, last_arg = 8'h00;
  int failures = 0, num_checks = 0, starts = 0;

  always #50 clk = ~clk;

  jse_top #(.SECTORS(12)) dut (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chip_reset(chip_reset), .nvm_dedicate(nvm_dedicate),
    .pin_enable_term(pin_enable_term), .flash_busy(flash_busy),
    .sec_write_busy(sec_write_busy), .flash_fail(flash_fail), .flash_done(flash_done),
    .flash_cmd(flash_cmd), .flash_arg(flash_arg), .flash_start(flash_start),
    .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .port_active(port_active), .gpio_stat_o(gpio_stat_o),
    .gpio_stat_oe(gpio_stat_oe), .gpio_err_o(gpio_err_o), .gpio_err_oe(gpio_err_oe),
    .flash_status_out(flash_status_out), .flash_status_oe(flash_status_oe),
    .flash_error_out(flash_error_out), .flash_error_oe(flash_error_oe)
  );

  jse_jtag_ctl u_ctl (.clk(clk), .tdo(tdo_o), .tck_pin(tck_pin), .tms_pin(tms_pin),
    .tdi_pin(tdi_pin), .rx_byte(rx_byte));

  // Launch log and serial-out drive watch
  always @(posedge clk) begin
    if (flash_start === 1'b1) begin
      starts <= starts + 1;
      last_cmd <= flash_cmd;
      last_arg <= flash_arg;
    end
    if (tdo_oe === 1'b1) saw_oe <= 1'b1;
  end

  // ------------------------------------------------------------
  // Reporting, compares and bus access
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic single cycle; request held until ack is sampled, no fixed latency assumed
  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
    if (wb_ack_o !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask

  // Chip reset held long enough to pass the synchroniser
  task automatic chip_pulse;
    chip_reset <= 1'b1;
    cyc(4);
    chip_reset <= 1'b0;
    cyc(6);
  endtask

  task automatic fail_pulse;
    flash_fail <= 1'b1;
    cyc(1);
    flash_fail <= 1'b0;
    cyc(2);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, JSE_TPE_IDX, 32'h0);
    chk_reg(rdat, {24'h0, JSE_TPE_RST});
    wb(1'b0, 8'h00, 32'h0);
    chk_reg(rdat, JSE_ZERO32); // Unmapped place reads zero
    chk_pin(port_active, 1'b0);
    // Extensions off: pins follow general I/O, chosen opposite to flash state
    flash_busy <= 1'b1;
    cyc(3);
    chk_pin(flash_status_out, 1'b1);
    chk_pin(flash_error_out, 1'b0);
    chk_pin(flash_error_oe, 1'b1);
    flash_busy <= 1'b0;
    // Each enable source alone opens the port
    for (i = 0; i < 3; i++) begin
      nvm_dedicate <= (i == 0);
      pin_enable_term <= (i == 1);
      if (i == 2) wb(1'b1, JSE_TPE_IDX, 32'h01);
      cyc(2);
      chk_pin(port_active, 1'b1);
    end
    wb(1'b1, JSE_TPE_IDX, 32'h00);
    cyc(2);
    chk_pin(port_active, 1'b0);
    nvm_dedicate <= 1'b1;
    // No serial drive and no extensions before the enter command
    saw_oe <= 1'b0;
    u_ctl.cmd(JSE_CMD_IDLE, 8'hA5);
    chk_pin(saw_oe, 1'b0);
    chk_pin(flash_error_out, 1'b0);
    u_ctl.cmd(JSE_CMD_ENTER, 8'h01);
    cyc(4);
    chk_pin(flash_status_oe, 1'b1);
    chk_pin(flash_error_out, 1'b1);
    saw_oe <= 1'b0;
    u_ctl.cmd(JSE_CMD_IDLE, 8'h00);
    chk_pin(saw_oe, 1'b1);
    // Status pin against both busy sources
    flash_busy <= 1'b1;
    cyc(3);
    chk_pin(flash_status_out, 1'b0);
    flash_busy <= 1'b0;
    sec_write_busy <= 1'b1;
    cyc(3);
    chk_pin(flash_status_out, 1'b0);
    sec_write_busy <= 1'b0;
    cyc(3);
    chk_pin(flash_status_out, 1'b1);
    // Error latch: survives chip reset without exit, dropped by clear
    fail_pulse();
    cyc(20);
    chk_pin(flash_error_out, 1'b0);
    wb(1'b1, JSE_TPE_IDX, 32'h01);
    chip_pulse();
    chk_pin(flash_error_out, 1'b0);
    chk_pin(port_active, 1'b1);
    wb(1'b0, JSE_TPE_IDX, 32'h0);
    chk_reg(rdat, 32'h0);
    u_ctl.cmd(JSE_CMD_CLEAR, 8'h00);
    cyc(4);
    chk_pin(flash_error_out, 1'b1);
    fail_pulse();
    u_ctl.cmd(JSE_CMD_EXIT, 8'h00);
    chip_pulse();
    wb(1'b0, JSE_STAT_IDX, 32'h0);
    chk_reg(rdat & 32'h8, 32'h0);
    // Open-drain option: released while ready, pulled low while busy
    u_ctl.cmd(JSE_CMD_ENTER, 8'h03);
    cyc(4);
    chk_pin(flash_status_oe, 1'b0);
    chk_pin(flash_error_oe, 1'b0);
    flash_busy <= 1'b1;
    cyc(3);
    chk_pin(flash_status_oe, 1'b1);
    chk_pin(flash_status_out, 1'b0);
    flash_busy <= 1'b0;
    // Secured: sector erase, program and verify never launch
    wb(1'b1, JSE_SEC_IDX, 32'h1);
    for (i = 0; i < 3; i++) begin
      u_ctl.cmd(JSE_CMD_SECT_ERASE + 8'(i), 8'h03);
    end
    chk_reg(starts, 32'h0);
    u_ctl.cmd(JSE_CMD_READ, 8'h00);
    chk_reg({24'h0, rx_byte}, {24'h0, JSE_ALL_ONES});
    u_ctl.cmd(JSE_CMD_CHIP_ERASE, 8'h00);
    chk_reg(starts, 32'h1);
    chk_reg({24'h0, last_cmd}, {24'h0, JSE_CMD_CHIP_ERASE});
    flash_done <= 1'b1;
    cyc(1);
    flash_done <= 1'b0;
    cyc(3);
    wb(1'b0, JSE_SEC_IDX, 32'h0);
    chk_reg(rdat, 32'h0);
    u_ctl.cmd(JSE_CMD_READ, 8'h00);
    chk_reg({24'h0, rx_byte}, 32'h0);
    // Protected sector refused, neighbour accepted
    wb(1'b1, JSE_PROT_IDX, 32'h004);
    u_ctl.cmd(JSE_CMD_SECT_ERASE, 8'h02);
    chk_reg(starts, 32'h1);
    u_ctl.cmd(JSE_CMD_SECT_ERASE, 8'h03);
    chk_reg(starts, 32'h2);
    chk_reg({24'h0, last_arg}, 32'h3);
    // Second reset, then register-only enable blocked by chip reset
    rst <= 1'b1;
    nvm_dedicate <= 1'b0;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk_pin(flash_status_oe, 1'b0);
    wb(1'b0, JSE_PROT_IDX, 32'h0);
    chk_reg(rdat, 32'h0);
    wb(1'b1, JSE_TPE_IDX, 32'h01);
    chip_reset <= 1'b1;
    cyc(4);
    u_ctl.cmd(JSE_CMD_ENTER, 8'h01);
    cyc(4);
    wb(1'b0, JSE_STAT_IDX, 32'h0);
    chk_reg(rdat & 32'h2, 32'h0);
    chip_reset <= 1'b0;
    cyc(4);
    wb(1'b1, JSE_TPE_IDX, 32'h01);
    u_ctl.cmd(JSE_CMD_ENTER, 8'h01);
    cyc(4);
    wb(1'b0, JSE_STAT_IDX, 32'h0);
    chk_reg(rdat & 32'h2, 32'h2);
    end_of_test();
  end
endmodule // jse_top_tb
